// ---- rtl/flsq_array.sv ----
// Flash word array held in flip-flops, with two read ports and program/erase.
// Assumes a program together with a page erase means erase, then write.
`timescale 1ns/100ps
module flsq_array
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Read ports
    input wire logic [flsq_pkg::FLSQ_WORD_AW-1:0] rd_a_addr_i,
    output logic [15:0] rd_a_data_o,
    input wire logic [flsq_pkg::FLSQ_WORD_AW-1:0] rd_b_addr_i,
    output logic [15:0] rd_b_data_o,
    // Modify controls
    input wire logic prog_i,
    input wire logic page_erase_i,
    input wire logic mass_erase_i,
    input wire logic [flsq_pkg::FLSQ_WORD_AW-1:0] mod_addr_i,
    input wire logic [15:0] mod_data_i
);
    import flsq_pkg::*;

    logic [15:0] word_reg [FLSQ_WORDS];

    // ==========================================================
    // Storage
    genvar gi;
    generate
        for (gi = 0; gi < FLSQ_WORDS; gi++)
        begin : g_word
            localparam logic [FLSQ_WORD_AW-1:0] WADR = FLSQ_WORD_AW'(gi);
            localparam bit KERNEL = (gi >> FLSQ_PAGE_AW) < FLSQ_KERNEL_PAGES;
            logic same_page;
            assign same_page = WADR[FLSQ_WORD_AW-1:FLSQ_PAGE_AW]
                == mod_addr_i[FLSQ_WORD_AW-1:FLSQ_PAGE_AW];
            always_ff @(posedge mclk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    word_reg[gi] <= FLSQ_ERASED;
                else if (prog_i && WADR == mod_addr_i)
                    word_reg[gi] <= mod_data_i;
                else if ((page_erase_i && same_page) || (mass_erase_i && !KERNEL))
                    word_reg[gi] <= FLSQ_ERASED;
            end
        end
    endgenerate

    assign rd_a_data_o = word_reg[rd_a_addr_i];
    assign rd_b_data_o = word_reg[rd_b_addr_i];

endmodule // flsq_array

// ---- rtl/flsq_pkg.sv ----
// Package of constants for the flash command sequencer.
// Assumes a 10 MHz core clock and an APB register bus with 32-bit data.
package flsq_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [31:0] FLSQ_ADR_STATUS = 32'hffff0e80;
    localparam logic [31:0] FLSQ_ADR_MODE = 32'hffff0e84;
    localparam logic [31:0] FLSQ_ADR_CMD = 32'hffff0e88;
    localparam logic [31:0] FLSQ_ADR_ADDR = 32'hffff0e8c;
    localparam logic [31:0] FLSQ_ADR_DATA = 32'hffff0e90;
    localparam logic [31:0] FLSQ_ADR_SIGN = 32'hffff0e98;
    localparam logic [31:0] FLSQ_ADR_PROT = 32'hffff0e9c;
    localparam logic [31:0] FLSQ_ADR_IRQ_STAT = 32'hffff0ea4;
    localparam logic [31:0] FLSQ_ADR_IRQ_EN = 32'hffff0ea8;
    localparam logic [31:0] FLSQ_ADR_IRQ_CLR = 32'hffff0eac;

    // ==========================================================
    // Reset values
    localparam logic [7:0] FLSQ_RST_MODE = 8'h80;
    localparam logic [7:0] FLSQ_RST_CMD = 8'h00;
    localparam logic [23:0] FLSQ_RST_SIGN = 24'hffffff;
    localparam logic [31:0] FLSQ_RST_PROT = 32'h00000000;
    localparam logic [15:0] FLSQ_ERASED = 16'hffff;

    // ==========================================================
    // Field positions
    localparam int FLSQ_ST_DONE = 0;
    localparam int FLSQ_ST_FAIL = 1;
    localparam int FLSQ_ST_BUSY = 2;
    localparam int FLSQ_ST_INT = 3;
    localparam int FLSQ_MD_WREN = 3;
    localparam int FLSQ_MD_INTEN = 4;
    localparam int FLSQ_IRQ_DONE = 0;
    localparam int FLSQ_IRQ_FAIL = 1;

    // ==========================================================
    // Command codes
    localparam logic [7:0] FLSQ_CMD_NULL = 8'h00;
    localparam logic [7:0] FLSQ_CMD_READ = 8'h01;
    localparam logic [7:0] FLSQ_CMD_WRITE = 8'h02;
    localparam logic [7:0] FLSQ_CMD_ERWR = 8'h03;
    localparam logic [7:0] FLSQ_CMD_VERIFY = 8'h04;
    localparam logic [7:0] FLSQ_CMD_ERASE = 8'h05;
    localparam logic [7:0] FLSQ_CMD_MASS = 8'h06;
    localparam logic [7:0] FLSQ_CMD_EXECUTED = 8'h07;
    localparam logic [7:0] FLSQ_CMD_SIGN = 8'h0b;
    localparam logic [7:0] FLSQ_CMD_PROTECT = 8'h0c;
    localparam logic [7:0] FLSQ_CMD_PING = 8'h0f;

    // ==========================================================
    // Array geometry: 16-bit words, pages of eight words
    localparam int FLSQ_WORD_AW = 6;
    localparam int FLSQ_WORDS = 64;
    localparam int FLSQ_PAGE_AW = 3;
    localparam int FLSQ_KERNEL_PAGES = 1;
    localparam logic [23:0] FLSQ_SIGN_POLY = 24'h864cfb;

    // ==========================================================
    // Timing
    localparam int FLSQ_CLK_MHZ = 10;
    localparam int FLSQ_T_WRITE_US = 50;
    localparam int FLSQ_T_ERWR_MS = 20;
    localparam int FLSQ_T_MASS_MS = 2480;
    localparam int FLSQ_SIGN_CYC = 32778;
    localparam int FLSQ_WRITE_CYC = FLSQ_T_WRITE_US * FLSQ_CLK_MHZ;
    localparam int FLSQ_ERWR_CYC = FLSQ_T_ERWR_MS * 1000 * FLSQ_CLK_MHZ;
    localparam int FLSQ_MASS_CYC = FLSQ_T_MASS_MS * 1000 * FLSQ_CLK_MHZ;
    localparam int FLSQ_CNT_W = 25;

endpackage

// ---- rtl/flsq_top.sv ----
// Flash command sequencer with APB registers, interrupt logic and fetch port.
// Assumes APB and the fetch requester run on mclk_i; fetch_req_i is held until ack.
//
// Summary of operation
// R1: Command 0x01 loads the data register with the addressed 16-bit word.
// R2: Command 0x02 programs the data register into the addressed word, about 50 us.
// R3: Command 0x03 erases the addressed page then programs the word, about 20 ms.
// R4: Command 0x04 compares the addressed word with data; mismatch sets status bit 1.
// R5: Command 0x05 erases only the page holding the addressed word.
// R6: Command 0x06 erases all but the kernel page, about 2.48 s, when guarded.
// R7: Command 0x0B computes a 24-bit signature over the array in 32,778 cycles.
// R8: Command 0x0C commits protection once; only mass erase releases it.
// R9: Command 0x0F does nothing except signal completion and interrupt.
// R10: After codes 0x00 to 0x06 execute the command register reads 0x07.
// R11: A 32-bit fetch takes two array read cycles, a 16-bit fetch one.
// R12: Status bit 2 is high exactly while a command is in progress.
// R13: Status bit 1 marks an unsuccessful command and clears on status read.
// R14: Status bit 3 sets on completion when mode bit 4 is set; clears on read.
// R15: Erase and program commands run only while mode bit 3 is set.
// R16: Code 0x00 and reserved codes start no flash operation.
// R17: Command register writes are ignored while a command is in progress.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module flsq_top
#(
    parameter int ERWR_CYCLES = flsq_pkg::FLSQ_ERWR_CYC,
    parameter int MASS_CYCLES = flsq_pkg::FLSQ_MASS_CYC,
    parameter int SIGN_CYCLES = flsq_pkg::FLSQ_SIGN_CYC
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Instruction fetch port
    input wire logic fetch_req_i,
    input wire logic fetch_wide_i,
    input wire logic [flsq_pkg::FLSQ_WORD_AW-1:0] fetch_addr_i,
    output logic [31:0] fetch_data_o,
    output logic fetch_ack_o,
    // Interrupt
    output logic irq_o
);
    import flsq_pkg::*;

    typedef enum logic [0:0] {FLSQ_IDLE, FLSQ_RUN} flsq_state_t;

    localparam logic [FLSQ_CNT_W-1:0] CNT_ERWR = FLSQ_CNT_W'(ERWR_CYCLES - 1);
    localparam logic [FLSQ_CNT_W-1:0] CNT_MASS = FLSQ_CNT_W'(MASS_CYCLES - 1);
    localparam logic [FLSQ_CNT_W-1:0] CNT_SIGN = FLSQ_CNT_W'(SIGN_CYCLES - 1);
    localparam logic [FLSQ_CNT_W-1:0] CNT_WRITE = FLSQ_CNT_W'(FLSQ_WRITE_CYC - 1);

    flsq_state_t state_reg;
    logic [FLSQ_CNT_W-1:0] cnt_reg;
    logic [7:0] op_reg;
    logic deny_reg;
    logic [7:0] mode_reg;
    logic [7:0] cmd_reg;
    logic [15:0] addr_reg;
    logic [15:0] data_reg;
    logic [23:0] sign_reg;
    logic [23:0] sig_acc_reg;
    logic [FLSQ_WORD_AW:0] sig_idx_reg;
    logic [31:0] prot_reg;
    logic [31:0] prot_lock_reg;
    logic prot_once_reg;
    logic done_reg;
    logic fail_reg;
    logic int_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_en_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic fetch_hi_reg;
    logic fetch_ack_reg;
    logic [15:0] fetch_lo_reg;
    logic [31:0] fetch_data_reg;

    logic setup;
    logic access;
    logic wr_acc;
    logic mapped;
    logic [31:0] rd_mux;
    logic cmd_go;
    logic [7:0] code;
    logic is_modify;
    logic page_ok;
    logic finish;
    logic ok_finish;
    logic fail_evt;
    logic [FLSQ_WORD_AW-1:0] word_adr;
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic [FLSQ_WORD_AW-1:0] seq_rd_adr;
    logic [FLSQ_WORD_AW-1:0] fetch_rd_adr;
    logic [23:0] sig_next;

    // ==========================================================
    // APB decode
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i && pready_reg;
    assign wr_acc = access && pwrite_i && !pslverr_reg;
    assign word_adr = addr_reg[FLSQ_WORD_AW:1];

    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr_i)
            FLSQ_ADR_STATUS: rd_mux = {28'h0000000, int_reg, state_reg == FLSQ_RUN,
                                       fail_reg, done_reg}; // [R12]
            FLSQ_ADR_MODE: rd_mux = {24'h000000, mode_reg};
            FLSQ_ADR_CMD: rd_mux = {24'h000000, cmd_reg};
            FLSQ_ADR_ADDR: rd_mux = {16'h0000, addr_reg};
            FLSQ_ADR_DATA: rd_mux = {16'h0000, data_reg};
            FLSQ_ADR_SIGN: rd_mux = {8'h00, sign_reg};
            FLSQ_ADR_PROT: rd_mux = prot_reg;
            FLSQ_ADR_IRQ_STAT: rd_mux = {30'h0, irq_stat_reg};
            FLSQ_ADR_IRQ_EN: rd_mux = {30'h0, irq_en_reg};
            FLSQ_ADR_IRQ_CLR: rd_mux = 32'h00000000;
            default: mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so that every output comes from a flop;
    // the access phase therefore completes with no wait states.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata_reg <= pwrite_i ? 32'h00000000 : rd_mux;
            pready_reg <= 1'b1;
            pslverr_reg <= !mapped;
        end
        else
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_reg <= FLSQ_RST_MODE;
            addr_reg <= 16'h0000;
            prot_reg <= FLSQ_RST_PROT;
            irq_en_reg <= 2'h0;
        end
        else if (wr_acc)
        begin
            if (paddr_i == FLSQ_ADR_MODE)
                mode_reg <= pwdata_i[7:0];
            if (paddr_i == FLSQ_ADR_ADDR)
                addr_reg <= pwdata_i[15:0];
            if (paddr_i == FLSQ_ADR_PROT)
                prot_reg <= pwdata_i;
            if (paddr_i == FLSQ_ADR_IRQ_EN)
                irq_en_reg <= pwdata_i[1:0];
        end
    end

    // ==========================================================
    // Command acceptance and permission
    assign code = pwdata_i[7:0];
    assign cmd_go = wr_acc && paddr_i == FLSQ_ADR_CMD && state_reg == FLSQ_IDLE; // [R17]
    assign is_modify = code == FLSQ_CMD_WRITE || code == FLSQ_CMD_ERWR
                       || code == FLSQ_CMD_ERASE || code == FLSQ_CMD_MASS;
    assign page_ok = !prot_once_reg || prot_lock_reg[word_adr[FLSQ_WORD_AW-1:FLSQ_PAGE_AW]];
    assign finish = state_reg == FLSQ_RUN && cnt_reg == '0;
    assign ok_finish = finish && !deny_reg;
    assign fail_evt = finish && (deny_reg
                      || (op_reg == FLSQ_CMD_VERIFY && word_a != data_reg)); // [R4]

    // A protect command is refused once protection has already been committed.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= FLSQ_IDLE;
            cnt_reg <= '0;
            op_reg <= FLSQ_CMD_NULL;
            deny_reg <= 1'b0;
        end
        else if (cmd_go)
        begin
            op_reg <= code;
            deny_reg <= (is_modify && !mode_reg[FLSQ_MD_WREN]) // [R15]
                        || (is_modify && code != FLSQ_CMD_MASS && !page_ok)
                        || (code == FLSQ_CMD_PROTECT && prot_once_reg);
            case (code)
                FLSQ_CMD_READ, FLSQ_CMD_VERIFY, FLSQ_CMD_PROTECT, FLSQ_CMD_PING:
                begin
                    state_reg <= FLSQ_RUN;
                    cnt_reg <= '0; // [R9]
                end
                FLSQ_CMD_WRITE:
                begin
                    state_reg <= FLSQ_RUN;
                    cnt_reg <= CNT_WRITE; // [R2]
                end
                FLSQ_CMD_ERWR, FLSQ_CMD_ERASE:
                begin
                    state_reg <= FLSQ_RUN;
                    cnt_reg <= CNT_ERWR; // [R3]
                end
                FLSQ_CMD_MASS:
                begin
                    state_reg <= FLSQ_RUN;
                    cnt_reg <= CNT_MASS; // [R6]
                end
                FLSQ_CMD_SIGN:
                begin
                    state_reg <= FLSQ_RUN;
                    cnt_reg <= CNT_SIGN; // [R7]
                end
                default:
                    state_reg <= FLSQ_IDLE; // [R16]
            endcase
        end
        else if (finish)
            state_reg <= FLSQ_IDLE; // [R12]
        else if (state_reg == FLSQ_RUN)
            cnt_reg <= cnt_reg - 1'b1;
    end

    // ==========================================================
    // Command register readback
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cmd_reg <= FLSQ_RST_CMD;
        else if (cmd_go)
            cmd_reg <= code == FLSQ_CMD_NULL ? FLSQ_CMD_EXECUTED : code; // [R10]
        else if (finish && op_reg <= FLSQ_CMD_MASS)
            cmd_reg <= FLSQ_CMD_EXECUTED; // [R10]
    end

    // ==========================================================
    // Data register: software writes, read command loads
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            data_reg <= 16'h0000;
        else if (ok_finish && op_reg == FLSQ_CMD_READ)
            data_reg <= word_a; // [R1]
        else if (wr_acc && paddr_i == FLSQ_ADR_DATA && state_reg == FLSQ_IDLE)
            data_reg <= pwdata_i[15:0];
    end

    // ==========================================================
    // Signature walk over every word, then the result waits for the count.
    assign sig_next = {sig_acc_reg[22:0], 1'b0} ^ {8'h00, word_a}
                      ^ (sig_acc_reg[23] ? FLSQ_SIGN_POLY : 24'h000000);
    assign seq_rd_adr = (state_reg == FLSQ_RUN && op_reg == FLSQ_CMD_SIGN)
                        ? sig_idx_reg[FLSQ_WORD_AW-1:0] : word_adr;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sig_acc_reg <= FLSQ_RST_SIGN;
            sig_idx_reg <= '0;
            sign_reg <= FLSQ_RST_SIGN;
        end
        else if (cmd_go)
        begin
            sig_acc_reg <= FLSQ_RST_SIGN;
            sig_idx_reg <= '0;
        end
        else if (state_reg == FLSQ_RUN && op_reg == FLSQ_CMD_SIGN)
        begin
            if (!sig_idx_reg[FLSQ_WORD_AW])
            begin
                sig_acc_reg <= sig_next; // [R7]
                sig_idx_reg <= sig_idx_reg + 1'b1;
            end
            if (finish)
                sign_reg <= sig_acc_reg; // [R7]
        end
    end

    // ==========================================================
    // Protection commit
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prot_lock_reg <= FLSQ_RST_PROT;
            prot_once_reg <= 1'b0;
        end
        else if (ok_finish && op_reg == FLSQ_CMD_PROTECT)
        begin
            prot_lock_reg <= prot_reg; // [R8]
            prot_once_reg <= 1'b1;
        end
        else if (ok_finish && op_reg == FLSQ_CMD_MASS)
            prot_once_reg <= 1'b0; // [R8]
    end

    // ==========================================================
    // Flash status bits; a completion in the read cycle survives the read clear.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            int_reg <= 1'b0;
        end
        else
        begin
            if (finish)
                done_reg <= 1'b1;
            else if (access && !pwrite_i && paddr_i == FLSQ_ADR_STATUS
                     && prdata_reg[FLSQ_ST_DONE])
                done_reg <= 1'b0;
            if (fail_evt)
                fail_reg <= 1'b1; // [R13]
            else if (access && !pwrite_i && paddr_i == FLSQ_ADR_STATUS
                     && prdata_reg[FLSQ_ST_FAIL])
                fail_reg <= 1'b0; // [R13]
            if (finish && mode_reg[FLSQ_MD_INTEN])
                int_reg <= 1'b1; // [R14] [R9]
            else if (access && !pwrite_i && paddr_i == FLSQ_ADR_STATUS
                     && prdata_reg[FLSQ_ST_INT])
                int_reg <= 1'b0; // [R14]
        end
    end

    // ==========================================================
    // Interrupt status, enable and clear
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_reg <= 2'h0;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~((wr_acc && paddr_i == FLSQ_ADR_IRQ_CLR)
                            ? pwdata_i[1:0] : 2'h0)) | {fail_evt, finish};
            irq_reg <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // ==========================================================
    // Fetch port: the array is 16 bits wide, so a wide fetch reads two words.
    assign fetch_rd_adr = fetch_hi_reg ? fetch_addr_i + 1'b1 : fetch_addr_i;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fetch_hi_reg <= 1'b0;
            fetch_ack_reg <= 1'b0;
            fetch_lo_reg <= 16'h0000;
            fetch_data_reg <= 32'h00000000;
        end
        else
        begin
            fetch_ack_reg <= 1'b0;
            if (fetch_hi_reg)
            begin
                fetch_data_reg <= {word_b, fetch_lo_reg}; // [R11]
                fetch_ack_reg <= 1'b1;
                fetch_hi_reg <= 1'b0;
            end
            else if (fetch_req_i && !fetch_ack_reg)
            begin
                fetch_lo_reg <= word_b;
                fetch_hi_reg <= fetch_wide_i; // [R11]
                if (!fetch_wide_i)
                begin
                    fetch_data_reg <= {16'h0000, word_b}; // [R11]
                    fetch_ack_reg <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Array
    flsq_array u_array
    (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .rd_a_addr_i(seq_rd_adr),
        .rd_a_data_o(word_a),
        .rd_b_addr_i(fetch_rd_adr),
        .rd_b_data_o(word_b),
        .prog_i(ok_finish && (op_reg == FLSQ_CMD_WRITE || op_reg == FLSQ_CMD_ERWR)),
        .page_erase_i(ok_finish && (op_reg == FLSQ_CMD_ERASE || op_reg == FLSQ_CMD_ERWR)), // [R5]
        .mass_erase_i(ok_finish && op_reg == FLSQ_CMD_MASS), // [R6]
        .mod_addr_i(word_adr),
        .mod_data_i(data_reg)
    );

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign fetch_data_o = fetch_data_reg;
    assign fetch_ack_o = fetch_ack_reg;
    assign irq_o = irq_reg;

endmodule // flsq_top

// ---- sim/flsq_top_props.sv ----
// Port checker for the flash command sequencer.
// Assumes one clock domain; bound to flsq_top from the testbench top file.
`timescale 1ns/100ps
module flsq_top_props
(
    // Bus, fetch and clocking ports
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic fetch_req_i,
    input wire logic fetch_wide_i,
    input wire logic [31:0] fetch_data_o,
    input wire logic fetch_ack_o
);
    import flsq_pkg::*;
    logic unm;
    assign unm = !(paddr_i inside {FLSQ_ADR_STATUS, FLSQ_ADR_MODE, FLSQ_ADR_CMD,
        FLSQ_ADR_ADDR, FLSQ_ADR_DATA, FLSQ_ADR_SIGN, FLSQ_ADR_PROT, FLSQ_ADR_IRQ_STAT,
        FLSQ_ADR_IRQ_EN, FLSQ_ADR_IRQ_CLR});
    // ==========================================================
    // Properties
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready missing after setup");
    a_ready_has_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("ready without setup");
    a_err_decode: assert property (psel_i && !penable_i |=> pslverr_o == $past(unm))
        else $error("slave error disagrees with decode");
    a_err_read_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("slave error without ready");
    a_ack_one_cycle: assert property (fetch_ack_o |=> !fetch_ack_o)
        else $error("fetch ack longer than one cycle");
    a_wide_two_reads: assert property (fetch_ack_o && fetch_wide_i |-> $past(fetch_req_i, 2))
        else $error("wide fetch answered too soon");
    a_narrow_upper: assert property (fetch_ack_o && !fetch_wide_i |-> fetch_data_o[31:16] == 16'h0)
        else $error("narrow fetch upper half not zero");
endmodule // flsq_top_props

// ---- sim/test_flash_command_sequencer.sv ----
// Self-checking bench for the flash command sequencer over APB and fetch.
// Assumes flsq_pkg, the design and the checker are compiled before this file.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_flash_command_sequencer;
    import flsq_pkg::*;
    logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, se;
    logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, fetch_data_o, rd, st;
    logic pready_o, pslverr_o, fetch_req_i = 0, fetch_wide_i = 0, fetch_ack_o, irq_o;
    logic [5:0] fetch_addr_i = 0;
    logic [7:0] rsv [6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
    int n_errors = 0, n_tests = 0, n;
    always #50 mclk_i = ~mclk_i;
    // Short counts keep erase runs brief.
    flsq_top #(.ERWR_CYCLES(20), .MASS_CYCLES(30), .SIGN_CYCLES(70)) u_flsq_top (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .fetch_req_i(fetch_req_i),
        .fetch_wide_i(fetch_wide_i), .fetch_addr_i(fetch_addr_i),
        .fetch_data_o(fetch_data_o), .fetch_ack_o(fetch_ack_o), .irq_o(irq_o));
    task print_verdict;
        $display("Errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Access tasks; answers are taken at the rising edge that shows them.
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (k == 20)
        begin
            n_errors++;
            print_verdict;
        end
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task run(input logic [7:0] c, input logic [31:0] d);
        int k;
        bus(1, FLSQ_ADR_DATA, d);
        bus(1, FLSQ_ADR_CMD, {24'h0, c});
        st = 0;
        for (k = 0; k < 200 && st[0] !== 1'b1; k++)
        begin
            bus(0, FLSQ_ADR_STATUS, 0);
            st = rd;
        end
        if (k == 200)
        begin
            n_errors++;
            print_verdict;
        end
    endtask
    task rdw(input logic [31:0] a);
        bus(1, FLSQ_ADR_ADDR, a);
        run(FLSQ_CMD_READ, 0);
        bus(0, FLSQ_ADR_DATA, 0);
    endtask
    task fetch(input logic w);
        @(posedge mclk_i);
        fetch_req_i <= 1'b1;
        fetch_wide_i <= w;
        fetch_addr_i <= 6'h08;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end while (fetch_ack_o !== 1'b1 && n < 10);
        if (n == 10)
        begin
            n_errors++;
            print_verdict;
        end
        rd = fetch_data_o;
        fetch_req_i <= 1'b0;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        bus(0, FLSQ_ADR_MODE, 0); `CHK(rd, 32'h80)
        bus(0, FLSQ_ADR_SIGN, 0); `CHK(rd, 32'hffffff)
        bus(0, FLSQ_ADR_CMD, 0); `CHK(rd, 32'h0)
        bus(0, 32'hffff0e94, 0); `CHK({se, rd}, 33'h100000000)
        bus(1, FLSQ_ADR_MODE, 32'h18);
        bus(1, FLSQ_ADR_IRQ_EN, 32'h3);
        bus(1, FLSQ_ADR_ADDR, 32'h10);
        run(FLSQ_CMD_WRITE, 32'h1234); `CHK({irq_o, st[3:0]}, 5'h19)
        bus(0, FLSQ_ADR_CMD, 0); `CHK(rd, 32'h7)
        bus(0, FLSQ_ADR_STATUS, 0); `CHK(rd[3:0], 4'h0)
        bus(0, FLSQ_ADR_IRQ_STAT, 0); `CHK(rd, 32'h1)
        bus(1, FLSQ_ADR_IRQ_CLR, 32'h3);
        bus(0, FLSQ_ADR_IRQ_STAT, 0); `CHK({irq_o, rd}, 33'h0)
        bus(1, FLSQ_ADR_IRQ_EN, 32'h0);
        run(FLSQ_CMD_PING, 0); `CHK({irq_o, st[3:0]}, 5'h09)
        bus(1, FLSQ_ADR_IRQ_CLR, 32'h3);
        rdw(32'h10); `CHK(rd, 32'h1234)
        run(FLSQ_CMD_VERIFY, 32'h1234); `CHK(st[1:0], 2'b01)
        run(FLSQ_CMD_VERIFY, 32'h0); `CHK(st[1:0], 2'b11)
        bus(0, FLSQ_ADR_STATUS, 0); `CHK(rd[1:0], 2'b00)
        fetch(1); `CHK({n[3:0], rd}, 36'h3ffff1234)
        fetch(0); `CHK({n[3:0], rd}, 36'h200001234)
        bus(1, FLSQ_ADR_DATA, 32'h5678);
        bus(1, FLSQ_ADR_CMD, {24'h0, FLSQ_CMD_ERWR});
        bus(1, FLSQ_ADR_CMD, {24'h0, FLSQ_CMD_PING});
        bus(0, FLSQ_ADR_STATUS, 0); `CHK(rd[2], 1'b1)
        run(FLSQ_CMD_READ, 0);
        run(FLSQ_CMD_READ, 0);
        bus(0, FLSQ_ADR_DATA, 0); `CHK(rd, 32'h5678)
        bus(1, FLSQ_ADR_ADDR, 32'h1e);
        run(FLSQ_CMD_ERASE, 0);
        rdw(32'h10); `CHK(rd, 32'hffff)
        bus(1, FLSQ_ADR_MODE, 32'h10);
        run(FLSQ_CMD_WRITE, 32'h0); `CHK(st[1:0], 2'b11)
        bus(1, FLSQ_ADR_MODE, 32'h18);
        bus(1, FLSQ_ADR_ADDR, 32'h0);
        run(FLSQ_CMD_WRITE, 32'haa);
        run(FLSQ_CMD_PROTECT, 0); `CHK(st[1:0], 2'b01)
        run(FLSQ_CMD_PROTECT, 0); `CHK(st[1:0], 2'b11)
        run(FLSQ_CMD_MASS, 0); `CHK(st[1:0], 2'b01)
        rdw(32'h0); `CHK(rd, 32'haa)
        run(FLSQ_CMD_SIGN, 0); `CHK(st[1:0], 2'b01)
        foreach (rsv[i])
        begin
            bus(1, FLSQ_ADR_CMD, {24'h0, rsv[i]});
            bus(0, FLSQ_ADR_STATUS, 0); `CHK(rd[2:0], 3'h0)
            bus(0, FLSQ_ADR_CMD, 0); `CHK(rd, {24'h0, rsv[i]})
        end
        bus(1, FLSQ_ADR_CMD, 32'h0);
        bus(0, FLSQ_ADR_CMD, 0); `CHK(rd, 32'h7)
        print_verdict;
    end
endmodule // test_flash_command_sequencer
bind flsq_top flsq_top_props u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .fetch_req_i(fetch_req_i),
    .fetch_wide_i(fetch_wide_i), .fetch_data_o(fetch_data_o), .fetch_ack_o(fetch_ack_o));
